// ==== hw/iav_ctrl.sv ====
// Purpose: priority arbitration, vector generation and accept/return sequencing
// Assumes: cpu issues trap, return and mask-write strobes synchronously
// Notes:   handler fetch is one cycle; stack push/pop are strobes to the core
`timescale 1ns/1ns

module iav_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  ext_pin_irq_n_i,
    input  wire logic [5:0]  timer8_irq_i,
    input  wire logic [2:0]  serial_rx_irq_i,
    input  wire logic [2:0]  serial_tx_irq_i,
    input  wire logic        hs_serial_irq_i,
    input  wire logic        hs_select_i,
    input  wire logic [1:0]  i2c_done_irq_i,
    input  wire logic [3:0]  timer16_match_irq_i,
    input  wire logic [1:0]  timer16_overflow_irq_i,
    input  wire logic        adc_done_irq_i,
    input  wire logic [86:0] src_level_i,
    input  wire logic        nmi_pin_i,
    input  wire logic        watchdog_irq_i,
    input  wire logic        soft_trap_i,
    input  wire logic [2:0]  soft_trap_num_i,
    input  wire logic        illegal_instr_i,
    input  wire logic        mask_write_i,
    input  wire logic [2:0]  mask_value_i,
    input  wire logic        first_instr_done_i,
    input  wire logic        return_i,
    output logic [2:0]       cpu_priority_mask_o,
    output logic [3:0]       nesting_depth_counter_o,
    output logic [2:0]       pending_level_o,
    output logic             irq_request_o,
    output logic             accept_o,
    output logic [7:0]       vector_o,
    output logic [7:0]       dma_start_code_o,
    output logic [23:0]      table_addr_o,
    output logic             stack_push_o,
    output logic             stack_pop_o,
    output logic             busy_o
);

    typedef enum logic [1:0] {IAV_IDLE, IAV_FETCH, IAV_WAIT} iav_state_t;

    typedef struct packed {
        iav_state_t                      state;
        logic [iav_pkg::NUM_SRC-1:0]     pend;
        logic [iav_pkg::NUM_SRC-1:0]     src_prev;
        logic                            nmi_prev;
        logic                            nmi_pend;
        logic                            wdt_pend;
        logic                            nmi_active;
        logic [2:0]                      mask;
        logic [3:0]                      nest;
        logic [2:0]                      plevel;
        logic                            req;
        logic                            acc;
        logic [7:0]                      vec;
        logic [7:0]                      dma;
        logic [23:0]                     taddr;
        logic                            push;
        logic                            pop;
        logic                            busy;
    } iav_st_t;

    iav_st_t st_reg;
    iav_st_t st_next;

    // -----------------------------------------------------------
    // source gathering
    // -----------------------------------------------------------
    logic [iav_pkg::NUM_SRC-1:0] src_raw;
    always_comb begin
        src_raw = {adc_done_irq_i,
                   timer16_overflow_irq_i[1], timer16_match_irq_i[3:2],
                   timer16_overflow_irq_i[0], timer16_match_irq_i[1:0],
                   i2c_done_irq_i,
                   serial_tx_irq_i[2], serial_rx_irq_i[2],
                   (hs_select_i ? hs_serial_irq_i : serial_tx_irq_i[1]),
                   serial_rx_irq_i[1], serial_tx_irq_i[0], serial_rx_irq_i[0],
                   timer8_irq_i,
                   ~ext_pin_irq_n_i};
    end

    // one index selects vector and start code, so both stay in step
    function automatic logic [7:0] vec_of(input int i);
        return iav_pkg::VEC_TAB[i];
    endfunction

    function automatic logic [7:0] dma_of(input int i);
        return iav_pkg::DMA_TAB[i];
    endfunction

    function automatic logic [2:0] lvl_of(input int i, input logic [86:0] lv);
        return lv[3*i +: 3];
    endfunction

    // -----------------------------------------------------------
    // arbitration
    // -----------------------------------------------------------
    logic [2:0] best_lvl;
    int         best_idx;
    logic       mask_ok;
    logic       nmi_any;
    logic [7:0] nmi_vec;
    logic       sample_ok;

    always_comb begin
        best_lvl = 3'h0;
        best_idx = 0;
        // ascending index, strict compare keeps smallest vector at equal level
        for (int i = 0; i < iav_pkg::NUM_SRC; i++) begin
            if (st_reg.pend[i] && lvl_of(i, src_level_i) != 3'h0 &&
                lvl_of(i, src_level_i) != 3'h7 &&
                lvl_of(i, src_level_i) > best_lvl) begin
                best_lvl = lvl_of(i, src_level_i);
                best_idx = i;
            end
        end
        nmi_any = st_reg.nmi_pend | st_reg.wdt_pend;
        nmi_vec = st_reg.nmi_pend ? iav_pkg::VEC_NMI : iav_pkg::VEC_WDT;
        if (nmi_any)
            best_lvl = iav_pkg::LVL_NMI;
        // nmi during nmi service only when the watchdog is pending
        mask_ok = (best_lvl != 3'h0) && (best_lvl >= st_reg.mask) &&
                  (!nmi_any || !st_reg.nmi_active || st_reg.wdt_pend);
        sample_ok = (st_reg.state == IAV_IDLE);
    end

    // -----------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.acc      = 1'b0;
        st_next.push     = 1'b0;
        st_next.pop      = 1'b0;
        st_next.src_prev = src_raw;
        st_next.nmi_prev = nmi_pin_i;
        // rising edges latch pending (watchdog on level); source set beats clear in same cycle, nmi/wdt clear wins
        st_next.pend     = st_reg.pend;
        if (nmi_pin_i && !st_reg.nmi_prev)
            st_next.nmi_pend = 1'b1;
        if (watchdog_irq_i)
            st_next.wdt_pend = 1'b1;
        st_next.plevel = best_lvl;
        st_next.req    = mask_ok && sample_ok;
        if (mask_write_i)
            st_next.mask = mask_value_i;
        unique case (st_reg.state)
            IAV_IDLE: begin
                if (soft_trap_i || illegal_instr_i) begin
                    st_next.vec = illegal_instr_i ? iav_pkg::VEC_ILLEGAL :
                                  8'({soft_trap_num_i, 2'b00});
                    st_next.dma   = 8'h00;
                    st_next.push  = 1'b1;
                    st_next.nest  = st_reg.nest + iav_pkg::NEST_W_ONE;
                    st_next.acc   = 1'b1;
                    st_next.state = IAV_FETCH;
                end else if (mask_ok) begin
                    if (nmi_any) begin
                        st_next.vec = nmi_vec;
                        st_next.dma = 8'h00;
                        st_next.nmi_active = 1'b1;
                        if (st_reg.nmi_pend)
                            st_next.nmi_pend = 1'b0;
                        else
                            st_next.wdt_pend = 1'b0;
                    end else begin
                        st_next.vec = vec_of(best_idx);
                        st_next.dma = dma_of(best_idx);
                        st_next.pend[best_idx] = 1'b0;
                    end
                    st_next.mask = (best_lvl == iav_pkg::LVL_NMI) ?
                                   iav_pkg::LVL_NMI : best_lvl + 3'h1;
                    st_next.push  = 1'b1;
                    st_next.nest  = st_reg.nest + iav_pkg::NEST_W_ONE;
                    st_next.acc   = 1'b1;
                    st_next.state = IAV_FETCH;
                end else if (return_i) begin
                    st_next.pop  = 1'b1;
                    st_next.nest = st_reg.nest - iav_pkg::NEST_W_ONE;
                    if (st_reg.nest == iav_pkg::NEST_W_ONE)
                        st_next.nmi_active = 1'b0;
                end
            end
            IAV_FETCH: begin
                st_next.taddr = iav_pkg::TABLE_BASE | {16'h0000, st_reg.vec};
                st_next.state = IAV_WAIT;
            end
            IAV_WAIT: begin
                if (first_instr_done_i)
                    st_next.state = IAV_IDLE;
            end
            default: st_next.state = IAV_IDLE;
        endcase
        for (int i = 0; i < iav_pkg::NUM_SRC; i++) begin
            if (src_raw[i] && !st_reg.src_prev[i])
                st_next.pend[i] = 1'b1;
        end
        st_next.busy = (st_next.state != IAV_IDLE);
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg      <= '0;
            st_reg.mask <= iav_pkg::MASK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cpu_priority_mask_o     = st_reg.mask;
    assign nesting_depth_counter_o = st_reg.nest;
    assign pending_level_o         = st_reg.plevel;
    assign irq_request_o           = st_reg.req;
    assign accept_o                = st_reg.acc;
    assign vector_o                = st_reg.vec;
    assign dma_start_code_o        = st_reg.dma;
    assign table_addr_o            = st_reg.taddr;
    assign stack_push_o            = st_reg.push;
    assign stack_pop_o             = st_reg.pop;
    assign busy_o                  = st_reg.busy;

    // -----------------------------------------------------------
    // checks: entry sequence
    // -----------------------------------------------------------
    sequence s_accept;
        accept_o && stack_push_o;
    endsequence

    // a concurrent mask write would legally move the mask
    sequence s_trap_entry;
        accept_o && ($past(soft_trap_i) || $past(illegal_instr_i)) && !$past(mask_write_i);
    endsequence

    sequence s_mask_entry;
        accept_o && vector_o >= 8'h28;
    endsequence

    a_reset_mask_val: assert property (@(posedge mclk_i)
        $rose(arst_n_i) |-> cpu_priority_mask_o == 3'h7)
        else $error("mask not 7 after reset");

    a_nest_inc_acc: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(accept_o) |-> nesting_depth_counter_o ==
            $past(nesting_depth_counter_o) + 4'h1)
        else $error("nesting not incremented");

    a_nest_no_wrap: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_o |-> nesting_depth_counter_o != 4'h0)
        else $error("nesting counter wrapped");

    a_push_with_acc: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_o |-> stack_push_o)
        else $error("accept without push");

    a_push_only_entry: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        stack_push_o |-> accept_o)
        else $error("push without accept");

    a_push_one_shot: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        stack_push_o |=> !stack_push_o)
        else $error("push longer than one cycle");

    a_trap_keeps_mask: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_trap_entry |-> cpu_priority_mask_o == $past(cpu_priority_mask_o))
        else $error("trap changed the mask");

    a_mask_plus_one: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_mask_entry |-> cpu_priority_mask_o == $past(best_lvl) + 3'h1)
        else $error("mask not level plus one");

    a_nmi_mask_seven: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_o && (vector_o == 8'h20 || vector_o == 8'h24) |-> cpu_priority_mask_o == 3'h7)
        else $error("nmi mask not 7");

    a_level_legal: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_mask_entry |-> $past(best_lvl) inside {[3'h1:3'h6]} &&
            $past(best_lvl) >= $past(st_reg.mask))
        else $error("level not acceptable");

    a_request_taken: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        irq_request_o |-> accept_o)
        else $error("request without accept");

    a_start_code_range: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_mask_entry |-> dma_start_code_o >= 8'h0a && dma_start_code_o <= 8'h30)
        else $error("start code out of range");

    a_adc_location: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_mask_entry && dma_start_code_o == 8'h30 |-> vector_o == 8'hc0)
        else $error("adc vector wrong");

    // -----------------------------------------------------------
    // checks: handler entry, table and return
    // -----------------------------------------------------------
    a_busy_after_acc: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        accept_o |-> busy_o)
        else $error("accept without busy");

    a_no_sample_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o |=> !(accept_o && !$past(soft_trap_i) && !$past(illegal_instr_i)))
        else $error("accepted while busy");

    a_vector_kept: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        busy_o && !accept_o |-> $stable(vector_o))
        else $error("vector moved during entry");

    a_table_addr_fetch: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_accept |=> table_addr_o == (24'hffff00 | {16'h0000, vector_o}))
        else $error("bad table address");

    a_table_range: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        table_addr_o != 24'h0 |-> table_addr_o[23:8] == 16'hffff)
        else $error("address outside table");

    a_pop_dec_nest: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        stack_pop_o |-> nesting_depth_counter_o ==
            $past(nesting_depth_counter_o) - 4'h1)
        else $error("nesting not decremented");

    a_pop_not_busy: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        stack_pop_o |-> !busy_o)
        else $error("pop during entry");

    a_pop_no_accept: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        stack_pop_o |-> !accept_o)
        else $error("pop together with accept");

endmodule

// ==== hw/iav_pkg.sv ====
// Purpose: constants for interrupt acceptance and vectoring
// Assumes: 25 MHz system clock, one clock domain
// Notes:   vectors are byte offsets into the table region
package iav_pkg;
    localparam int          NUM_SRC       = 29;
    localparam logic [2:0]  LVL_NMI       = 3'h7;
    localparam logic [2:0]  MASK_RESET    = 3'h7;
    localparam logic [23:0] TABLE_BASE    = 24'hffff00;
    localparam logic [23:0] TABLE_LAST    = 24'hffffff;
    localparam logic [7:0]  VEC_SOFT0     = 8'h00;
    localparam logic [7:0]  VEC_STEP      = 8'h04;
    localparam logic [7:0]  VEC_ILLEGAL   = 8'h08;
    localparam logic [7:0]  VEC_NMI       = 8'h20;
    localparam logic [7:0]  VEC_WDT       = 8'h24;
    localparam logic [3:0]  NEST_W_ONE    = 4'h1;
    // maskable source table, index order is default order (smallest vector first)
    localparam logic [7:0] VEC_TAB [NUM_SRC] = '{
        8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44,
        8'h48, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c,
        8'h68, 8'h6c, 8'h70, 8'h74, 8'h78, 8'h7c,
        8'h88, 8'h90,
        8'ha8, 8'hac, 8'hb0, 8'hb4, 8'hb8, 8'hbc,
        8'hc0};
    localparam logic [7:0] DMA_TAB [NUM_SRC] = '{
        8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11,
        8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
        8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
        8'h22, 8'h24,
        8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
        8'h30};
    localparam int SRC_TX1   = 17;
    localparam int SRC_ADC   = 28;
endpackage

// ==== testbench/iav_cpu_model.sv ====
// Purpose: behavioural cpu core retiring the first handler instruction
// Assumes: one accept pulse opens one handler entry
// Notes:   fixed entry time; a slower core only needs a larger HOLD
`timescale 1ns/1ns
module iav_cpu_model #(
    parameter int HOLD = 6
) (
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic accept_i,
    output logic      first_instr_done_o
);
    int cnt_reg;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg            <= 0;
            first_instr_done_o <= 1'b0;
        end else begin
            first_instr_done_o <= (cnt_reg == 1);
            cnt_reg            <= accept_i ? HOLD : (cnt_reg > 0 ? cnt_reg - 1 : 0);
        end
    end
endmodule

// ==== testbench/interrupt_accept_vectoring_bench.sv ====
// Purpose: self-checking bench for interrupt acceptance and vectoring
// Assumes: cpu model retires the first handler instruction HOLD+1 cycles after accept
// Notes:   expected vectors and start codes are worked out here
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module interrupt_accept_vectoring_bench;
    logic        mclk_i = '0, arst_n_i = '0, hs_serial_irq_i = '0, hs_select_i = '0;
    logic        adc_done_irq_i = '0, nmi_pin_i = '0, watchdog_irq_i = '0, soft_trap_i = '0;
    logic        illegal_instr_i = '0, mask_write_i = '0, return_i = '0, first_instr_done_i;
    logic [7:0]  ext_pin_irq_n_i = 8'hff, vector_o, dma_start_code_o;
    logic [5:0]  timer8_irq_i = '0;
    logic [3:0]  timer16_match_irq_i = '0, nesting_depth_counter_o, nest_exp = 4'h0;
    logic [2:0]  serial_rx_irq_i = '0, serial_tx_irq_i = '0, soft_trap_num_i = '0;
    logic [2:0]  mask_value_i = '0, cpu_priority_mask_o, pending_level_o;
    logic [1:0]  i2c_done_irq_i = '0, timer16_overflow_irq_i = '0;
    logic [86:0] src_level_i = '0;
    logic [23:0] table_addr_o;
    logic        irq_request_o, accept_o, stack_push_o, stack_pop_o, busy_o;
    int          n_errors = 0, checked = 0;
    always #20 mclk_i = ~mclk_i;
    iav_ctrl DUT (
        .mclk_i, .arst_n_i, .ext_pin_irq_n_i, .timer8_irq_i, .serial_rx_irq_i,
        .serial_tx_irq_i, .hs_serial_irq_i, .hs_select_i, .i2c_done_irq_i, .timer16_match_irq_i,
        .timer16_overflow_irq_i, .adc_done_irq_i, .src_level_i, .nmi_pin_i, .watchdog_irq_i,
        .soft_trap_i, .soft_trap_num_i, .illegal_instr_i, .mask_write_i, .mask_value_i,
        .first_instr_done_i, .return_i, .cpu_priority_mask_o, .nesting_depth_counter_o,
        .pending_level_o, .irq_request_o, .accept_o, .vector_o, .dma_start_code_o,
        .table_addr_o, .stack_push_o, .stack_pop_o, .busy_o);
    iav_cpu_model #(.HOLD(6)) cpu (.mclk_i, .arst_n_i, .accept_i(accept_o),
        .first_instr_done_o(first_instr_done_i));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic guard(input int k, input int lim);  // a used-up wait ends the run
        `CHECK("wait", 1'b1, k < lim)
        if (k >= lim) print_verdict();
    endtask
    task automatic fire();  // strobes last one cycle, then idle levels return
        tick();
        {ext_pin_irq_n_i, timer8_irq_i, serial_rx_irq_i, serial_tx_irq_i} = {8'hff, 12'h0};
        {hs_serial_irq_i, i2c_done_irq_i, timer16_match_irq_i, timer16_overflow_irq_i} = 9'h0;
        {adc_done_irq_i, nmi_pin_i, watchdog_irq_i, soft_trap_i} = 4'h0;
        {illegal_instr_i, mask_write_i, return_i} = 3'h0;
    endtask
    function automatic logic [15:0] code_of(input int i);  // vector, then start code
        if (i < 14) return {8'(8'h28 + 4*i), 8'(8'h0a + i)};
        if (i < 20) return {8'(8'h68 + 4*(i-14)), 8'(8'h1a + i - 14)};
        if (i < 22) return (i == 20) ? 16'h8822 : 16'h9024;
        if (i < 28) return {8'(8'ha8 + 4*(i-22)), 8'(8'h2a + i - 22)};
        return (i == 28) ? 16'hc030 : 16'h741d;
    endfunction
    task automatic set_src(input int i, input logic [2:0] l);  // index 29 is hs serial
        src_level_i[(i == 29 ? 17 : i)*3 +: 3] = l;
        hs_select_i = (i == 29);
        case (i) inside
            [0:7]:   ext_pin_irq_n_i[i] = 1'b0;
            [8:13]:  timer8_irq_i[i-8] = 1'b1;
            [14:19]: if (i % 2 == 0) serial_rx_irq_i[(i-14)/2] = 1'b1;
                     else serial_tx_irq_i[(i-14)/2] = 1'b1;
            [20:21]: i2c_done_irq_i[i-20] = 1'b1;
            [22:23]: timer16_match_irq_i[i-22] = 1'b1;
            24:      timer16_overflow_irq_i[0] = 1'b1;
            [25:26]: timer16_match_irq_i[i-23] = 1'b1;
            27:      timer16_overflow_irq_i[1] = 1'b1;
            28:      adc_done_irq_i = 1'b1;
            default: hs_serial_irq_i = 1'b1;
        endcase
    endtask
    task automatic set_mask(input logic [2:0] v);
        mask_value_i = v;
        mask_write_i = 1'b1;
        fire();
        tick();
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 40 && busy_o !== 1'b0; k++) tick();
        guard(k, 40);
    endtask
    task automatic idle_for(input int n);
        repeat (n) begin
            tick();
            `CHECK("no accept", 1'b0, accept_o)
        end
    endtask
    task automatic take(input logic [7:0] ev, input logic [2:0] em, input bit cv);
        int k;
        for (k = 0; k < 40 && accept_o !== 1'b1; k++) tick();
        guard(k, 40);
        `CHECK("push", 1'b1, stack_push_o)
        `CHECK("request", cv, irq_request_o)
        nest_exp++;
        tick();
        `CHECK("table", {16'hffff, ev}, table_addr_o)
        `CHECK("vector", ev, vector_o)
        `CHECK("mask", em, cpu_priority_mask_o)
        `CHECK("nest", nest_exp, nesting_depth_counter_o)
    endtask
    task automatic leave();
        int k;
        wait_idle();
        return_i = 1'b1;
        fire();
        for (k = 0; k < 10 && stack_pop_o !== 1'b1; k++) tick();
        guard(k, 10);
        nest_exp--;
        tick();
        `CHECK("nest", nest_exp, nesting_depth_counter_o)
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        `CHECK("reset mask", 3'h7, cpu_priority_mask_o)
        `CHECK("reset nest", 4'h0, nesting_depth_counter_o)
        tick();
        set_src(0, 3'h2);
        set_src(9, 3'h5);
        fire();
        idle_for(4);
        `CHECK("pending level", 3'h5, pending_level_o)
        `CHECK("no request", 1'b0, irq_request_o)
        set_mask(3'h5);
        take(8'h4c, 3'h6, 1);
        wait_idle();
        set_mask(3'h2);
        take(8'h28, 3'h3, 1);
        leave();
        leave();
        $display("test mask compare done");
        src_level_i = '0;
        set_src(20, 3'h0);
        set_src(21, 3'h7);
        fire();
        set_mask(3'h1);
        idle_for(6);
        $display("test disabled levels done");
        for (int i = 0; i <= 29; i++) begin
            src_level_i = '0;
            set_mask(3'h1);
            set_src(i, 3'h1);
            fire();
            take(code_of(i)[15:8], 3'h2, 1);
            `CHECK("start code", code_of(i)[7:0], dma_start_code_o)
            leave();
        end
        $display("test vector table done");
        set_mask(3'h1);
        set_src(13, 3'h3);
        set_src(7, 3'h3);
        fire();
        take(8'h44, 3'h4, 1);
        wait_idle();
        set_mask(3'h3);
        take(8'h5c, 3'h4, 1);
        leave();
        leave();
        $display("test default order done");
        set_mask(3'h1);
        set_src(3, 3'h2);
        fire();
        take(8'h34, 3'h3, 1);
        set_src(5, 3'h5);
        fire();
        idle_for(2);
        take(8'h3c, 3'h6, 1);
        leave();
        leave();
        set_mask(3'h7);
        nmi_pin_i = 1'b1;
        fire();
        take(8'h20, 3'h7, 1);
        watchdog_irq_i = 1'b1;
        fire();
        idle_for(2);
        take(8'h24, 3'h7, 1);
        leave();
        leave();
        $display("test preemption done");
        set_mask(3'h2);
        for (int n = 0; n < 9; n++) begin
            soft_trap_num_i = 3'(n);
            soft_trap_i = (n < 8);
            illegal_instr_i = (n == 8);
            fire();
            take((n < 8) ? 8'(4*n) : 8'h08, 3'h2, 0);
            leave();
        end
        $display("test traps done");
        print_verdict();
    end
endmodule
